// ### common/uart_host_map.svh
// Constants of the UART host-bus, DMA request and sleep control block
// Assumes inclusion by uart_host_pkg only; holds definitions and nothing else
// Notes on behaviour
// - Strap picks dual or single strobe bus.
// - Dual strobe: chip select, then read/write strobe.
// - Single strobe: write strobe sampled at select fall.
// - Queue-control DMA and enable bits pick single/block transfers.
// - Single: tx request while transmitter empty.
// - Single: rx request while any character held.
// - Block: tx request at trigger, off when full.
// - Block: rx request at trigger/timeout, off empty/error.
// - Sleep allowed when enhanced and sleep enables set.
// - Sleep needs idle line, empty tx, no interrupts.
// - No sleep while receive queue holds data.
// - Asleep stops UART and baud clocks.
// - Wake on line edge, modem change, tx write.
// - Address lines pick default register set.
// - Line-control bit 7 maps divisor bytes.
// - Line-control top bits 100 map alternate function.
// - Special line-control value maps enhanced and flow chars.
// - Enhanced plus modem bit 6 map threshold/trigger.
// - Offset 7 fractional divisor under four conditions.
// - Offset 7 read gives queue-ready status with modem bit 2 set, bit 4 clear.
// - Guarded bits change only with enhanced bit set.
`ifndef UART_HOST_MAP_SVH
`define UART_HOST_MAP_SVH
// Synchronised pin vector layout
`define PIN_W 20
`define PIN_DATA_LSB 0
`define PIN_ADDR_LSB 8
`define PIN_CS 11
`define PIN_RDS 12
`define PIN_WRS 13
`define PIN_RX 14
`define PIN_MODEM_LSB 15
`define PIN_MODE 19
// Register offsets
`define OFS_0 3'h0
`define OFS_1 3'h1
`define OFS_2 3'h2
`define OFS_3 3'h3
`define OFS_4 3'h4
`define OFS_5 3'h5
`define OFS_6 3'h6
`define OFS_7 3'h7
// Access conditions and field positions
`define LC_SPECIAL 8'hBF
`define LC_ALT_TOP 3'h4
`define BIT_LC_DIV 7
`define BIT_EF_ENH 4
`define BIT_IE_SLEEP 4
`define BIT_QC_EN 0
`define BIT_QC_RXCLR 1
`define BIT_QC_TXCLR 2
`define BIT_QC_DMA 3
`define BIT_MC_RDY 2
`define BIT_MC_LOOP 4
`define BIT_MC_TT 6
`define BIT_RDY_TX 0
`define BIT_RDY_RX 1
`define FIFO_DEPTH 8'h80
// Reset values
`define RST_ZERO 8'h00
`define RST_LC 8'h1D
`define RST_AF 8'h10
`define RST_RESUME1 8'hFF
`define RST_RESUME2 8'hEF
`endif

// ### common/uart_host_pkg.sv
// Types of the UART host-bus, DMA request and sleep control block
// Assumes the constants header is on the include path
package uart_host_pkg;
`include "uart_host_map.svh"

  typedef enum logic [2:0] {
    ACC_IDLE = 3'b001,
    ACC_READ = 3'b010,
    ACC_WRITE = 3'b100
  } access_state_t;

  typedef enum logic [4:0] {
    SEL_NONE, SEL_HOLD, SEL_DIV_LO, SEL_DIV_HI, SEL_INT_EN, SEL_IDENT_QC, SEL_ALT, SEL_ENH,
    SEL_LINE, SEL_MODEM_CTL, SEL_RES1, SEL_RES2, SEL_LINE_ST, SEL_MODEM_ST, SEL_PAUSE1,
    SEL_THRESH, SEL_PAUSE2, SEL_TRIG, SEL_FRAC, SEL_READY, SEL_SCRATCH
  } reg_sel_t;

  typedef struct packed {
    logic [7:0] divisor_low_byte;
    logic [7:0] divisor_high_byte;
    logic [7:0] interrupt_enable;
    logic [7:0] queue_control;
    logic [7:0] alternate_function;
    logic [7:0] enhanced_feature;
    logic [7:0] line_control;
    logic [7:0] modem_control;
    logic [7:0] flow_resume_char_1;
    logic [7:0] flow_resume_char_2;
    logic [7:0] flow_pause_char_1;
    logic [7:0] flow_pause_char_2;
    logic [7:0] flow_threshold_control;
    logic [7:0] trigger_level_control;
    logic [7:0] fractional_divisor;
    logic [7:0] scratch_byte;
  } cfg_regs_t;

  typedef struct packed {
    logic [7:0] rx_count;
    logic [7:0] tx_count;
    logic [7:0] rx_trigger_level;
    logic [7:0] tx_trigger_spaces;
    logic tx_shift_empty;
    logic rx_line_idle;
    logic rx_timeout;
    logic other_int_pending;
    logic rx_fifo_error;
    logic [7:0] receive_holding;
    logic [7:0] interrupt_ident;
    logic [7:0] line_status;
    logic [7:0] modem_status;
  } core_status_t;

  typedef struct packed {
    logic [`PIN_W-1:0] s1;
    logic [`PIN_W-1:0] s2;
    logic [`PIN_W-1:0] s3;
    logic [`PIN_W-1:0] pins;
    access_state_t acc;
    logic [2:0] addr;
    logic [7:0] wdata;
    cfg_regs_t cfg;
    logic [7:0] rdata;
    logic data_oe;
    logic tx_load;
    logic [7:0] tx_data;
    logic rx_take;
    logic [1:0] fifo_clear;
    logic tx_req_n;
    logic rx_req_n;
    logic asleep;
    logic clk_run;
  } state_t;

endpackage

// ### logic/uart_host_dma_sleep_regsel.sv
// Host bus slave, register selection, DMA request pins and sleep control of a UART
// Assumes bus pins and wake pins are asynchronous; core status comes from core_clk_i logic
`timescale 1ns/1ps

module uart_host_dma_sleep_regsel
  import uart_host_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  // Processor bus pins
  input wire logic mode_strap_i,
  input wire logic cs_n_i,
  input wire logic read_strobe_n_i,
  input wire logic write_strobe_n_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  // Wake pins
  input wire logic rx_pin_i,
  input wire logic [3:0] modem_pins_i,
  // UART core status
  input wire core_status_t core_i,
  // UART core control
  output cfg_regs_t cfg_o,
  output logic tx_load_o,
  output logic [7:0] tx_data_o,
  output logic rx_take_o,
  output logic [1:0] fifo_clear_o,
  // DMA request pins
  output logic tx_dma_request_n_o,
  output logic rx_dma_request_n_o,
  // Sleep and clock gating
  output logic sleep_o,
  output logic uart_clk_run_o,
  output logic baud_clk_run_o
);

  // ==========================================================
  // Reset image
  localparam cfg_regs_t CFG_RST = '{
    divisor_low_byte: `RST_ZERO,
    divisor_high_byte: `RST_ZERO,
    interrupt_enable: `RST_ZERO,
    queue_control: `RST_ZERO,
    alternate_function: `RST_AF,
    enhanced_feature: `RST_ZERO,
    line_control: `RST_LC,
    modem_control: `RST_ZERO,
    flow_resume_char_1: `RST_RESUME1,
    flow_resume_char_2: `RST_RESUME2,
    flow_pause_char_1: `RST_ZERO,
    flow_pause_char_2: `RST_ZERO,
    flow_threshold_control: `RST_ZERO,
    trigger_level_control: `RST_ZERO,
    fractional_divisor: `RST_ZERO,
    scratch_byte: `RST_ZERO
  };

  localparam state_t STATE_RST = '{
    s1: '1,
    s2: '1,
    s3: '1,
    pins: '1,
    acc: ACC_IDLE,
    addr: 3'h0,
    wdata: 8'h00,
    cfg: CFG_RST,
    rdata: 8'h00,
    data_oe: 1'b0,
    tx_load: 1'b0,
    tx_data: 8'h00,
    rx_take: 1'b0,
    fifo_clear: 2'h0,
    tx_req_n: 1'b1,
    rx_req_n: 1'b1,
    asleep: 1'b0,
    clk_run: 1'b1
  };

  state_t q;
  state_t d;

  // ==========================================================
  // Register selection
  function automatic reg_sel_t decode(input logic [2:0] a, input cfg_regs_t c, input logic rd);
    logic special;
    logic div;
    logic enh;
    logic tt;
    logic excl;
    reg_sel_t s;
    special = (c.line_control == `LC_SPECIAL);
    div = c.line_control[`BIT_LC_DIV];
    enh = c.enhanced_feature[`BIT_EF_ENH];
    tt = enh & c.modem_control[`BIT_MC_TT];
    excl = c.modem_control[`BIT_MC_TT] & ~c.modem_control[`BIT_MC_LOOP] & c.modem_control[`BIT_MC_RDY];
    s = SEL_NONE;
    case (a)
      `OFS_0: s = div ? SEL_DIV_LO : SEL_HOLD;
      `OFS_1: s = div ? SEL_DIV_HI : SEL_INT_EN;
      `OFS_2: begin
        if (special) begin
          s = SEL_ENH;
        end else if (c.line_control[7:5] == `LC_ALT_TOP) begin
          s = SEL_ALT;
        end else begin
          s = SEL_IDENT_QC;
        end
      end
      `OFS_3: s = SEL_LINE;
      `OFS_4: s = special ? SEL_RES1 : SEL_MODEM_CTL;
      `OFS_5: begin
        if (special) begin
          s = SEL_RES2;
        end else begin
          s = rd ? SEL_LINE_ST : SEL_NONE;
        end
      end
      `OFS_6: begin
        if (special) begin
          s = SEL_PAUSE1;
        end else if (tt) begin
          s = SEL_THRESH;
        end else begin
          s = rd ? SEL_MODEM_ST : SEL_NONE;
        end
      end
      `OFS_7: begin
        if (special) begin
          s = SEL_PAUSE2;
        end else if (div & enh & ~excl) begin
          s = SEL_FRAC;
        end else if (tt) begin
          s = SEL_TRIG;
        end else if (rd & c.modem_control[`BIT_MC_RDY] & ~c.modem_control[`BIT_MC_LOOP]) begin
          s = SEL_READY;
        end else begin
          s = SEL_SCRATCH;
        end
      end
      default: s = SEL_NONE;
    endcase
    return s;
  endfunction

  // ==========================================================
  // Next state
  logic dual;
  logic cs_act;
  logic rd_act;
  logic wr_act;
  logic rx_chg;
  logic modem_chg;
  logic enh_on;
  logic single_dma;
  logic [7:0] tx_free;
  logic sleep_allow;
  logic idle_ok;
  logic wake;
  logic acc_end;
  reg_sel_t rsel;
  reg_sel_t wsel;

  always_comb begin
    d = q;
    // ====================
    // Three-stage pin synchronisers; a level counts once stages two and three agree
    d.s1 = {mode_strap_i, modem_pins_i, rx_pin_i, write_strobe_n_i, read_strobe_n_i, cs_n_i, addr_i, data_i};
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < `PIN_W; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.pins[i] = q.s3[i];
      end
    end
    rx_chg = (q.s2[`PIN_RX] == q.s3[`PIN_RX]) && (q.s3[`PIN_RX] != q.pins[`PIN_RX]);
    modem_chg = 1'b0;
    for (int j = `PIN_MODEM_LSB; j < `PIN_MODEM_LSB + 4; j++) begin
      if ((q.s2[j] == q.s3[j]) && (q.s3[j] != q.pins[j])) begin
        modem_chg = 1'b1;
      end
    end

    dual = q.pins[`PIN_MODE];
    cs_act = ~q.pins[`PIN_CS];
    rd_act = ~q.pins[`PIN_RDS];
    wr_act = ~q.pins[`PIN_WRS];
    enh_on = q.cfg.enhanced_feature[`BIT_EF_ENH];
    rsel = decode(q.addr, q.cfg, 1'b1);
    wsel = decode(q.addr, q.cfg, 1'b0);
    acc_end = 1'b0;
    d.tx_load = 1'b0;
    d.rx_take = 1'b0;
    d.fifo_clear = 2'h0;

    // ====================
    // Bus access sequencing
    case (q.acc)
      ACC_IDLE: begin
        d.data_oe = 1'b0;
        d.addr = q.pins[`PIN_ADDR_LSB +: 3];
        d.wdata = q.pins[`PIN_DATA_LSB +: 8];
        if (cs_act) begin
          if (dual) begin
            if (rd_act) begin
              d.acc = ACC_READ;
            end else if (wr_act) begin
              d.acc = ACC_WRITE;
            end
          end else begin
            d.acc = wr_act ? ACC_WRITE : ACC_READ;
          end
        end
      end
      ACC_READ: begin
        acc_end = dual ? (~cs_act | ~rd_act) : ~cs_act;
        d.data_oe = ~acc_end;
        case (rsel)
          SEL_HOLD: d.rdata = core_i.receive_holding;
          SEL_DIV_LO: d.rdata = q.cfg.divisor_low_byte;
          SEL_DIV_HI: d.rdata = q.cfg.divisor_high_byte;
          SEL_INT_EN: d.rdata = q.cfg.interrupt_enable;
          SEL_IDENT_QC: d.rdata = core_i.interrupt_ident;
          SEL_ALT: d.rdata = q.cfg.alternate_function;
          SEL_ENH: d.rdata = q.cfg.enhanced_feature;
          SEL_LINE: d.rdata = q.cfg.line_control;
          SEL_MODEM_CTL: d.rdata = q.cfg.modem_control;
          SEL_RES1: d.rdata = q.cfg.flow_resume_char_1;
          SEL_RES2: d.rdata = q.cfg.flow_resume_char_2;
          SEL_LINE_ST: d.rdata = core_i.line_status;
          SEL_MODEM_ST: d.rdata = core_i.modem_status;
          SEL_PAUSE1: d.rdata = q.cfg.flow_pause_char_1;
          SEL_THRESH: d.rdata = q.cfg.flow_threshold_control;
          SEL_PAUSE2: d.rdata = q.cfg.flow_pause_char_2;
          SEL_TRIG: d.rdata = q.cfg.trigger_level_control;
          SEL_FRAC: d.rdata = q.cfg.fractional_divisor;
          SEL_SCRATCH: d.rdata = q.cfg.scratch_byte;
          SEL_READY: begin
            d.rdata = 8'h00;
            d.rdata[`BIT_RDY_TX] = ~q.tx_req_n;
            d.rdata[`BIT_RDY_RX] = ~q.rx_req_n;
          end
          default: d.rdata = 8'h00;
        endcase
        if (acc_end) begin
          d.acc = ACC_IDLE;
          d.rx_take = (rsel == SEL_HOLD);
        end
      end
      ACC_WRITE: begin
        acc_end = dual ? (~cs_act | ~wr_act) : ~cs_act;
        d.data_oe = 1'b0;
        // Data tracks the pins until the end is seen, so the last settled byte is written
        if (!acc_end) begin
          d.wdata = q.pins[`PIN_DATA_LSB +: 8];
        end else begin
          d.acc = ACC_IDLE;
          case (wsel)
            SEL_HOLD: begin
              d.tx_load = 1'b1;
              d.tx_data = q.wdata;
            end
            SEL_DIV_LO: d.cfg.divisor_low_byte = q.wdata;
            SEL_DIV_HI: d.cfg.divisor_high_byte = q.wdata;
            SEL_INT_EN: begin
              d.cfg.interrupt_enable[3:0] = q.wdata[3:0];
              if (enh_on) begin
                d.cfg.interrupt_enable[7:4] = q.wdata[7:4];
              end
            end
            SEL_IDENT_QC: begin
              d.cfg.queue_control = {q.cfg.queue_control[7:6], q.cfg.queue_control[5:4], q.wdata[3], 2'b00, q.wdata[0]};
              d.cfg.queue_control[7:6] = q.wdata[7:6];
              if (enh_on) begin
                d.cfg.queue_control[5:4] = q.wdata[5:4];
              end
              d.fifo_clear = {q.wdata[`BIT_QC_TXCLR], q.wdata[`BIT_QC_RXCLR]};
            end
            SEL_ALT: d.cfg.alternate_function = q.wdata;
            SEL_ENH: d.cfg.enhanced_feature = q.wdata;
            SEL_LINE: d.cfg.line_control = q.wdata;
            SEL_MODEM_CTL: begin
              d.cfg.modem_control[4:0] = q.wdata[4:0];
              if (enh_on) begin
                d.cfg.modem_control[7:5] = q.wdata[7:5];
              end
            end
            SEL_RES1: d.cfg.flow_resume_char_1 = q.wdata;
            SEL_RES2: d.cfg.flow_resume_char_2 = q.wdata;
            SEL_PAUSE1: d.cfg.flow_pause_char_1 = q.wdata;
            SEL_THRESH: d.cfg.flow_threshold_control = q.wdata;
            SEL_PAUSE2: d.cfg.flow_pause_char_2 = q.wdata;
            SEL_TRIG: d.cfg.trigger_level_control = q.wdata;
            SEL_FRAC: d.cfg.fractional_divisor = q.wdata;
            SEL_SCRATCH: d.cfg.scratch_byte = q.wdata;
            default: d.cfg = q.cfg;
          endcase
        end
      end
      default: begin
        d.acc = ACC_IDLE;
        d.data_oe = 1'b0;
      end
    endcase

    // ====================
    // DMA request pins, stored active low
    // Block mode holds each request between its set and clear levels
    single_dma = ~q.cfg.queue_control[`BIT_QC_DMA] | ~q.cfg.queue_control[`BIT_QC_EN];
    tx_free = `FIFO_DEPTH - core_i.tx_count;
    if (single_dma) begin
      d.tx_req_n = (core_i.tx_count != 8'h00);
      d.rx_req_n = (core_i.rx_count == 8'h00);
    end else begin
      if (core_i.tx_count >= `FIFO_DEPTH) begin
        d.tx_req_n = 1'b1;
      end else if (tx_free >= core_i.tx_trigger_spaces) begin
        d.tx_req_n = 1'b0;
      end
      if ((core_i.rx_count == 8'h00) || core_i.rx_fifo_error) begin
        d.rx_req_n = 1'b1;
      end else if ((core_i.rx_count >= core_i.rx_trigger_level) || core_i.rx_timeout) begin
        d.rx_req_n = 1'b0;
      end
    end

    // ====================
    // Sleep entry and wake
    // A wake event blocks entry in the same cycle so it is never lost
    sleep_allow = enh_on & q.cfg.interrupt_enable[`BIT_IE_SLEEP];
    idle_ok = core_i.rx_line_idle & (core_i.tx_count == 8'h00) & core_i.tx_shift_empty
      & ~core_i.other_int_pending;
    idle_ok = idle_ok & (core_i.rx_count == 8'h00);
    wake = rx_chg | modem_chg | d.tx_load;
    if (q.asleep) begin
      if (wake || !sleep_allow) begin
        d.asleep = 1'b0;
      end
    end else if (sleep_allow && idle_ok && !wake) begin
      d.asleep = 1'b1;
    end
    d.clk_run = ~d.asleep;
  end

  // ==========================================================
  // State register
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= STATE_RST;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // Outputs
  assign data_o = q.rdata;
  assign data_oe_o = q.data_oe;
  assign cfg_o = q.cfg;
  assign tx_load_o = q.tx_load;
  assign tx_data_o = q.tx_data;
  assign rx_take_o = q.rx_take;
  assign fifo_clear_o = q.fifo_clear;
  assign tx_dma_request_n_o = q.tx_req_n;
  assign rx_dma_request_n_o = q.rx_req_n;
  assign sleep_o = q.asleep;
  assign uart_clk_run_o = q.clk_run;
  assign baud_clk_run_o = q.clk_run;

endmodule

// ### bench/uart_host_sva.sv
// Checker of the UART host block: DMA request pins, sleep entry, wake and clock gating
// Assumes binding to uart_host_dma_sleep_regsel; sees its ports only
`timescale 1ns/1ps
module uart_host_sva
  import uart_host_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  // Watched ports
  input wire core_status_t core_i,
  input wire cfg_regs_t cfg_o,
  input wire logic tx_load_o,
  input wire logic tx_dma_request_n_o,
  input wire logic rx_dma_request_n_o,
  input wire logic sleep_o,
  input wire logic uart_clk_run_o,
  input wire logic baud_clk_run_o
);
  // ==========================================================
  // Helpers
  logic blk;
  logic allow;
  logic quiet;
  assign blk = cfg_o.queue_control[3] & cfg_o.queue_control[0];
  assign allow = cfg_o.enhanced_feature[4] & cfg_o.interrupt_enable[4];
  assign quiet = core_i.rx_line_idle & (core_i.tx_count == 8'h00) & core_i.tx_shift_empty & !core_i.other_int_pending;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  // ==========================================================
  // Sequences
  sequence s_blk_rx_hit;
    blk && core_i.rx_count != 8'h00 && !core_i.rx_fifo_error
      && (core_i.rx_count >= core_i.rx_trigger_level || core_i.rx_timeout);
  endsequence
  sequence s_blk_tx_hit;
    blk && core_i.tx_count < 8'h80 && (8'h80 - core_i.tx_count) >= core_i.tx_trigger_spaces;
  endsequence
  sequence s_enter;
    !sleep_o ##1 sleep_o;
  endsequence

  // ==========================================================
  // Assertions
  a_single_tx_req: assert property (!blk |=> tx_dma_request_n_o == ($past(core_i.tx_count) != 8'h00))
    else $error("tx request wrong in single mode");
  a_single_rx_req: assert property (!blk |=> rx_dma_request_n_o == ($past(core_i.rx_count) == 8'h00))
    else $error("rx request wrong in single mode");
  a_block_tx_on: assert property (s_blk_tx_hit |=> !tx_dma_request_n_o)
    else $error("tx request not raised at trigger");
  a_block_tx_full: assert property (blk && core_i.tx_count >= 8'h80 |=> tx_dma_request_n_o)
    else $error("tx request active with full queue");
  a_block_rx_on: assert property (s_blk_rx_hit |=> !rx_dma_request_n_o)
    else $error("rx request not raised at trigger");
  a_block_rx_off: assert property (blk && (core_i.rx_count == 8'h00 || core_i.rx_fifo_error) |=> rx_dma_request_n_o)
    else $error("rx request active when empty or in error");
  a_sleep_allow: assert property (s_enter |-> $past(allow))
    else $error("sleep entered without enables");
  a_sleep_drop: assert property (!allow |=> !sleep_o)
    else $error("sleep held after enables dropped");
  a_sleep_quiet: assert property (s_enter |-> $past(quiet))
    else $error("sleep entered while busy");
  a_sleep_rx_empty: assert property (s_enter |-> $past(core_i.rx_count) == 8'h00)
    else $error("sleep entered with receive data held");
  a_clock_gate: assert property (uart_clk_run_o == !sleep_o && baud_clk_run_o == !sleep_o)
    else $error("clock run outputs disagree with sleep");
  a_tx_wake: assert property (tx_load_o |-> !sleep_o)
    else $error("transmit write did not wake");
endmodule

bind uart_host_dma_sleep_regsel uart_host_sva u_chk (
  .core_clk_i(core_clk_i),
  .arst_n_i(arst_n_i),
  .core_i(core_i),
  .cfg_o(cfg_o),
  .tx_load_o(tx_load_o),
  .tx_dma_request_n_o(tx_dma_request_n_o),
  .rx_dma_request_n_o(rx_dma_request_n_o),
  .sleep_o(sleep_o),
  .uart_clk_run_o(uart_clk_run_o),
  .baud_clk_run_o(baud_clk_run_o)
);

// ### bench/uart_host_bus_model.sv
// Host processor model: read and write cycles on the parallel bus in either strobe style
// Assumes the strap level is shared with the device; the bench calls wr and rd
`timescale 1ns/1ps
module uart_host_bus_model (
  // Clock and style
  input wire logic clk_i,
  input wire logic mode_strap_i,
  // Bus pins
  output logic cs_n_o,
  output logic read_strobe_n_o,
  output logic write_strobe_n_o,
  output logic [2:0] addr_o,
  output logic [7:0] data_o,
  input wire logic [7:0] data_i,
  input wire logic data_oe_i
);
  initial begin
    cs_n_o = 1'b1;
    read_strobe_n_o = 1'b1;
    write_strobe_n_o = 1'b1;
    addr_o = 3'h0;
    data_o = 8'h00;
  end

  // Release scrambles address and data so stale values are never read as valid
  task automatic release_bus(input logic [7:0] last);
    cs_n_o = 1'b1;
    read_strobe_n_o = 1'b1;
    write_strobe_n_o = 1'b1;
    addr_o = ~addr_o;
    data_o = ~last;
    repeat (8) @(posedge clk_i);
    #1;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    addr_o = a;
    data_o = d;
    cs_n_o = 1'b0;
    write_strobe_n_o = 1'b0;
    repeat (8) @(posedge clk_i);
    #1;
    release_bus(d);
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    int n;
    @(posedge clk_i);
    #1;
    addr_o = a;
    cs_n_o = 1'b0;
    if (mode_strap_i) begin
      read_strobe_n_o = 1'b0;
    end
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (data_oe_i !== 1'b1 && n < 16);
    d = data_i;
    #1;
    release_bus(data_o);
  endtask
endmodule

// ### bench/test_uart_host_dma_sleep_regsel.sv
// Self-checking bench of the UART host block
// Assumes the host model drives the bus; the bench drives core status, strap and wake pins
`timescale 1ns/1ps
module test_uart_host_dma_sleep_regsel;
  import uart_host_pkg::*;
  logic core_clk_i, arst_n_i, mode_strap_i, cs_n, rds_n, wrs_n, data_oe_o, rx_pin_i;
  logic tx_load_o, rx_take_o, tx_req_n, rx_req_n, sleep_o, ucr, bcr, sleep_prev;
  logic [2:0] addr;
  logic [3:0] modem_pins_i;
  logic [1:0] fifo_clear_o, last_clr;
  logic [7:0] wdata, data_o, tx_data_o, rd, last_tx;
  core_status_t core_i;
  cfg_regs_t cfg_o;
  int err_total = 0, compares = 0, cycles = 0, wakes = 0, loads = 0, takes = 0, w;

  uart_host_dma_sleep_regsel DUT (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .mode_strap_i(mode_strap_i),
    .cs_n_i(cs_n), .read_strobe_n_i(rds_n), .write_strobe_n_i(wrs_n), .addr_i(addr), .data_i(wdata),
    .data_o(data_o), .data_oe_o(data_oe_o), .rx_pin_i(rx_pin_i), .modem_pins_i(modem_pins_i), .core_i(core_i),
    .cfg_o(cfg_o), .tx_load_o(tx_load_o), .tx_data_o(tx_data_o), .rx_take_o(rx_take_o),
    .fifo_clear_o(fifo_clear_o), .tx_dma_request_n_o(tx_req_n), .rx_dma_request_n_o(rx_req_n),
    .sleep_o(sleep_o), .uart_clk_run_o(ucr), .baud_clk_run_o(bcr));

  uart_host_bus_model hm (.clk_i(core_clk_i), .mode_strap_i(mode_strap_i), .cs_n_o(cs_n), .read_strobe_n_o(rds_n),
    .write_strobe_n_o(wrs_n), .addr_o(addr), .data_o(wdata), .data_i(data_o), .data_oe_i(data_oe_o));

  // ==========================================================
  // Clock, monitors and hang guard
  initial begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end

  always @(posedge core_clk_i) begin
    cycles++;
    if (tx_load_o === 1'b1) begin
      loads++;
      last_tx = tx_data_o;
    end
    if (sleep_prev === 1'b1 && sleep_o === 1'b0) begin
      wakes++;
    end
    sleep_prev = sleep_o;
    if (rx_take_o === 1'b1) begin
      takes++;
    end
    if (fifo_clear_o !== 2'h0) begin
      last_clr = fifo_clear_o;
    end
    if (cycles == 6000) begin
      err_total++;
      end_sim();
    end
  end

  // ==========================================================
  // Tasks
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
    hm.rd(a, rd);
    chk($sformatf("read offset %0d", a), exp, rd);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  task automatic dma(input logic [7:0] tx, input logic [7:0] rx, input logic er, input logic to, input logic [1:0] e);
    core_i.tx_count = tx;
    core_i.rx_count = rx;
    core_i.rx_fifo_error = er;
    core_i.rx_timeout = to;
    cyc(2);
    chk("request pins", {6'h00, e}, {6'h00, rx_req_n, tx_req_n});
  endtask

  task automatic end_sim();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    arst_n_i = 1'b0;
    mode_strap_i = 1'b1;
    rx_pin_i = 1'b1;
    modem_pins_i = 4'hF;
    core_i = '0;
    core_i.rx_line_idle = 1'b1;
    core_i.tx_shift_empty = 1'b1;
    core_i.rx_trigger_level = 8'h08;
    core_i.tx_trigger_spaces = 8'h10;
    core_i.receive_holding = 8'hC3;
    core_i.interrupt_ident = 8'h01;
    core_i.line_status = 8'h60;
    core_i.modem_status = 8'hB0;
    cyc(16);
    chk("line_control reset", 8'h1D, cfg_o.line_control);
    chk("resume 2 reset", 8'hEF, cfg_o.flow_resume_char_2);
    chk("tx request reset", 8'h01, {7'h00, tx_req_n});
    arst_n_i = 1'b1;
    cyc(8);
    hm.wr(3'h7, 8'h5A);
    rchk(3'h7, 8'h5A);
    rchk(3'h0, 8'hC3);
    chk("receive pops", 8'h01, 8'(takes));
    rchk(3'h2, 8'h01);
    rchk(3'h5, 8'h60);
    rchk(3'h6, 8'hB0);
    hm.wr(3'h0, 8'h3C);
    chk("tx byte", 8'h3C, last_tx);
    hm.wr(3'h1, 8'hF3);
    chk("interrupt_enable guard", 8'h03, cfg_o.interrupt_enable);
    hm.wr(3'h2, 8'h36);
    chk("queue_control guard", 8'h00, cfg_o.queue_control);
    chk("queue clear pulse", 8'h03, {6'h00, last_clr});
    hm.wr(3'h3, 8'h80);
    hm.wr(3'h0, 8'h12);
    hm.wr(3'h1, 8'h34);
    rchk(3'h0, 8'h12);
    rchk(3'h1, 8'h34);
    chk("divisor_high_byte", 8'h34, cfg_o.divisor_high_byte);
    hm.wr(3'h2, 8'h15);
    rchk(3'h2, 8'h15);
    hm.wr(3'h3, 8'hBF);
    rchk(3'h4, 8'hFF);
    hm.wr(3'h2, 8'h10);
    hm.wr(3'h5, 8'h22);
    hm.wr(3'h6, 8'h33);
    hm.wr(3'h7, 8'h44);
    rchk(3'h2, 8'h10);
    rchk(3'h5, 8'h22);
    chk("pause char 1", 8'h33, cfg_o.flow_pause_char_1);
    chk("pause char 2", 8'h44, cfg_o.flow_pause_char_2);
    hm.wr(3'h3, 8'h03);
    hm.wr(3'h1, 8'hE3);
    chk("interrupt_enable open", 8'hE3, cfg_o.interrupt_enable);
    hm.wr(3'h4, 8'h40);
    hm.wr(3'h6, 8'h55);
    hm.wr(3'h7, 8'h66);
    rchk(3'h6, 8'h55);
    chk("trigger level", 8'h66, cfg_o.trigger_level_control);
    hm.wr(3'h3, 8'h80);
    hm.wr(3'h7, 8'h2B);
    chk("fractional", 8'h2B, cfg_o.fractional_divisor);
    chk("trigger kept", 8'h66, cfg_o.trigger_level_control);
    hm.wr(3'h4, 8'h44);
    hm.wr(3'h7, 8'h3E);
    chk("excluded pattern", 8'h2B, cfg_o.fractional_divisor);
    chk("trigger via pattern", 8'h3E, cfg_o.trigger_level_control);
    hm.wr(3'h3, 8'h03);
    hm.wr(3'h4, 8'h04);
    core_i.rx_count = 8'h02;
    rchk(3'h7, 8'h03);
    dma(8'h01, 8'h02, 1'b0, 1'b0, 2'b01);
    dma(8'h00, 8'h00, 1'b0, 1'b0, 2'b10);
    hm.wr(3'h2, 8'h09);
    chk("queue_control", 8'h09, cfg_o.queue_control);
    dma(8'h80, 8'h00, 1'b0, 1'b0, 2'b11);
    dma(8'h78, 8'h04, 1'b0, 1'b0, 2'b11);
    dma(8'h70, 8'h08, 1'b0, 1'b0, 2'b00);
    dma(8'h78, 8'h04, 1'b0, 1'b0, 2'b00);
    dma(8'h80, 8'h04, 1'b1, 1'b0, 2'b11);
    dma(8'h00, 8'h02, 1'b0, 1'b1, 2'b00);
    dma(8'h00, 8'h03, 1'b0, 1'b0, 2'b00);
    hm.wr(3'h1, 8'hF3);
    cyc(6);
    chk("sleep with rx data", 8'h00, {7'h00, sleep_o});
    core_i.rx_count = 8'h00;
    core_i.other_int_pending = 1'b1;
    cyc(6);
    chk("sleep with interrupt", 8'h00, {7'h00, sleep_o});
    core_i.other_int_pending = 1'b0;
    cyc(3);
    chk("sleep entry", 8'h01, {7'h00, sleep_o});
    chk("clocks stopped", 8'h00, {6'h00, ucr, bcr});
    w = wakes;
    modem_pins_i = 4'hE;
    cyc(12);
    chk("modem wake", 8'(w + 1), 8'(wakes));
    rx_pin_i = 1'b0;
    cyc(12);
    chk("line wake", 8'(w + 2), 8'(wakes));
    hm.wr(3'h0, 8'h77);
    chk("write wake", 8'(w + 3), 8'(wakes));
    hm.wr(3'h1, 8'hE3);
    chk("sleep off", 8'h00, {7'h00, sleep_o});
    hm.wr(3'h3, 8'h80);
    hm.wr(3'h0, 8'h01);
    chk("divisor_low_byte", 8'h01, cfg_o.divisor_low_byte);
    mode_strap_i = 1'b0;
    cyc(8);
    hm.wr(3'h7, 8'hA5);
    rchk(3'h7, 8'hA5);
    end_sim();
  end
endmodule
